// >>> hdl/pus_pkg.sv
package pus_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [11:0] EXC_STATUS_OFS = 12'h000;
    localparam logic [11:0] GLB_STATUS_OFS = 12'h004;
    localparam logic [11:0] CTRL_OFS = 12'h008;
    localparam logic [11:0] SEQ_STATE_OFS = 12'h00c;

    // Field positions of the cause flags and control bits.
    localparam int EXC_PWRUP_BIT = 15;
    localparam int EXC_WDOG_BIT = 13;
    localparam int EXC_SELFTEST_BIT = 5;
    localparam int EXC_SW_BIT = 4;
    localparam int EXC_EXT_BIT = 3;
    localparam int GLB_OSC_BIT = 0;
    localparam int GLB_SLIP_LO_BIT = 8;
    localparam int GLB_SLIP_HI_BIT = 9;
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_LOWPWR_BIT = 1;

    // Implemented bits of each status word and reset values.
    localparam logic [15:0] EXC_MASK = 16'ha038;
    localparam logic [15:0] GLB_MASK = 16'h0301;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic CTRL_LOWPWR_RESET = 1'b0;

    // Clock period and documented filter windows, in nanoseconds.
    localparam int CLK_PERIOD_NS = 40;
    localparam int SUP_GLITCH_MIN_NS = 250;
    localparam int SUP_GLITCH_MAX_NS = 1000;
    localparam int PIN_FILT_MIN_NS = 475;
    localparam int PIN_FILT_MAX_NS = 2000;

    // Filter lengths: least times rounded up to whole cycles.
    localparam logic [4:0] SUP_FILT_CYC =
        5'((SUP_GLITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] PIN_FILT_CYC =
        5'((PIN_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Power-up phase lengths and reset pin hold times, in cycles.
    localparam logic [11:0] OSC_CYC = 12'd1032;
    localparam logic [11:0] FUSE_CYC = 12'd1160;
    localparam logic [11:0] PUMP_CYC = 12'd688;
    localparam logic [11:0] BANK_CYC = 12'd617;
    localparam logic [11:0] POR_HOLD_CYC = 12'd2256;
    localparam logic [5:0] WARM_VCLK_CYC = 6'd32;

    // First fetch address after the CPU reset is released.
    localparam logic [31:0] BOOT_ADDR = 32'h00000000;

    // Filter channel indices.
    localparam int FLT_CORE = 0;
    localparam int FLT_IO = 1;
    localparam int FLT_COLD = 2;
    localparam int FLT_WARM = 3;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_POR,
        ST_OSC,
        ST_FUSE,
        ST_PUMP,
        ST_BANK,
        ST_RUN,
        ST_WARM
    } pus_seq_type;

    // APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pus_apb_req_type;

    // APB answer to the master.
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pus_apb_rsp_type;

    // Reset request sources inside the chip, active high.
    typedef struct packed {
        logic osc_fail;
        logic pll_slip;
        logic watchdog;
        logic debug_reset;
        logic self_test_reset;
    } pus_evt_type;

endpackage : pus_pkg

// >>> hdl/pus_sequencer.sv
`timescale 1ns/1ps
module pus_sequencer #(
    parameter logic [7:0] VCLK_DIV = 8'd1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire pus_pkg::pus_apb_req_type apb_req,
    output pus_pkg::pus_apb_rsp_type apb_rsp,
    input wire logic core_supply_ok,
    input wire logic io_supply_ok,
    input wire logic cold_reset_pin_n,
    input wire logic warm_reset_pin_n_i,
    output logic warm_reset_pin_n_o,
    output logic warm_reset_pin_n_oe,
    input wire pus_pkg::pus_evt_type reset_evt,
    output logic core_power_good,
    output logic io_power_good,
    output logic core_isolate,
    output logic io_isolate,
    output logic pins_hiz,
    output logic por_int,
    output logic cpu_reset_n,
    output logic [31:0] cpu_boot_addr
);
    import pus_pkg::*;

    // Whole state of the block, registered in one place.
    typedef struct packed {
        pus_seq_type st;
        logic [11:0] phase_cnt;
        logic [11:0] hold_cnt;
        logic [5:0] warm_cnt;
        logic [7:0] vdiv_cnt;
        logic [3:0][4:0] filt_cnt;
        logic [3:0] filt_lvl;
        logic warm_prev;
        logic [15:0] exc_flags;
        logic [15:0] glb_flags;
        logic low_pwr;
        logic sw_req;
        logic [31:0] prdata;
    } pus_state_type;

    pus_state_type state_reg;
    pus_state_type state_next;

    // Decoded bus strobes.
    logic apb_setup;
    logic apb_write;
    logic addr_hit;
    // Power-on reset seen from the filtered levels.
    logic por_now;
    // Warm pin drive request, from registered state only.
    logic pin_drive;
    // Peripheral clock enable pulse.
    logic vclk_en;
    // Any warm reset cause in this cycle.
    logic warm_evt;
    logic ext_evt;
    logic [3:0] filt_raw;
    logic [15:0] exc_set;
    logic [15:0] glb_set;
    logic [15:0] exc_clr;
    logic [15:0] glb_clr;

    // Bus decode; the slave never inserts wait states.
    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_write = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign addr_hit = (apb_req.paddr == EXC_STATUS_OFS) || (apb_req.paddr == GLB_STATUS_OFS)
        || (apb_req.paddr == CTRL_OFS) || (apb_req.paddr == SEQ_STATE_OFS);

    // Power-on reset covers both supplies and the filtered cold pin.
    assign por_now = !state_reg.filt_lvl[FLT_CORE] || !state_reg.filt_lvl[FLT_IO]
        || !state_reg.filt_lvl[FLT_COLD];

    // The pin stays low through reset, the cold hold and any warm pulse.
    assign pin_drive = (state_reg.st == ST_POR) || (state_reg.st == ST_WARM)
        || (state_reg.hold_cnt < POR_HOLD_CYC);

    // Comparator samples; low power mode masks the supply monitor.
    assign filt_raw[FLT_CORE] = core_supply_ok || state_reg.low_pwr;
    assign filt_raw[FLT_IO] = io_supply_ok || state_reg.low_pwr;
    assign filt_raw[FLT_COLD] = cold_reset_pin_n;
    assign filt_raw[FLT_WARM] = warm_reset_pin_n_i;

    // An outside low on the warm pin counts only while we release it.
    assign ext_evt = state_reg.warm_prev && !state_reg.filt_lvl[FLT_WARM] && !pin_drive;

    assign warm_evt = reset_evt.osc_fail || reset_evt.pll_slip || reset_evt.watchdog
        || reset_evt.debug_reset || reset_evt.self_test_reset || state_reg.sw_req || ext_evt;

    // Cause flags; watchdog and debug reset share one bit, a PLL slip sets two.
    always_comb
    begin
        exc_set = 16'h0000;
        glb_set = 16'h0000;
        exc_set[EXC_PWRUP_BIT] = por_now;
        exc_set[EXC_WDOG_BIT] = reset_evt.watchdog || reset_evt.debug_reset;
        exc_set[EXC_SELFTEST_BIT] = reset_evt.self_test_reset;
        exc_set[EXC_SW_BIT] = state_reg.sw_req;
        exc_set[EXC_EXT_BIT] = ext_evt;
        glb_set[GLB_OSC_BIT] = reset_evt.osc_fail;
        glb_set[GLB_SLIP_LO_BIT] = reset_evt.pll_slip;
        glb_set[GLB_SLIP_HI_BIT] = reset_evt.pll_slip;
        exc_clr = 16'h0000;
        glb_clr = 16'h0000;
        // Software clears a flag by writing a one to it.
        if (apb_write && apb_req.paddr == EXC_STATUS_OFS)
        begin
            exc_clr = apb_req.pwdata[15:0] & EXC_MASK;
        end
        if (apb_write && apb_req.paddr == GLB_STATUS_OFS)
        begin
            glb_clr = apb_req.pwdata[15:0] & GLB_MASK;
        end
    end

    // Next-state logic for filters, sequencer, flags and bus.
    always_comb
    begin
        state_next = state_reg;
        vclk_en = 1'b0;

        // Each filter flips only after its input differs for the full length.
        for (int i = 0; i < 4; i++)
        begin
            if (filt_raw[i] == state_reg.filt_lvl[i])
            begin
                state_next.filt_cnt[i] = 5'h00;
            end
            else if (state_reg.filt_cnt[i] == ((i < 2) ? SUP_FILT_CYC : PIN_FILT_CYC) - 5'h01)
            begin
                state_next.filt_lvl[i] = filt_raw[i];
                state_next.filt_cnt[i] = 5'h00;
            end
            else
            begin
                state_next.filt_cnt[i] = state_reg.filt_cnt[i] + 5'h01;
            end
        end
        state_next.warm_prev = state_reg.filt_lvl[FLT_WARM];

        // Peripheral clock divider, used to time warm reset pulses.
        if (state_reg.vdiv_cnt >= VCLK_DIV - 8'h01)
        begin
            state_next.vdiv_cnt = 8'h00;
            vclk_en = 1'b1;
        end
        else
        begin
            state_next.vdiv_cnt = state_reg.vdiv_cnt + 8'h01;
        end

        // Cold hold counter runs from the release of power-on reset.
        if (state_reg.st == ST_POR)
        begin
            state_next.hold_cnt = 12'h000;
        end
        else if (state_reg.hold_cnt < POR_HOLD_CYC)
        begin
            state_next.hold_cnt = state_reg.hold_cnt + 12'h001;
        end

        // Power-up sequencer; power-on reset wins over every phase.
        state_next.phase_cnt = state_reg.phase_cnt + 12'h001;
        if (por_now)
        begin
            state_next.st = ST_POR;
            state_next.phase_cnt = 12'h000;
        end
        else
        begin
            case (state_reg.st)
                ST_POR:
                begin
                    // Supplies good and cold pin released: start the oscillator.
                    state_next.st = ST_OSC;
                    state_next.phase_cnt = 12'h000;
                end
                ST_OSC:
                begin
                    if (state_reg.phase_cnt == OSC_CYC - 12'h001)
                    begin
                        state_next.st = ST_FUSE;
                        state_next.phase_cnt = 12'h000;
                    end
                end
                ST_FUSE:
                begin
                    if (state_reg.phase_cnt == FUSE_CYC - 12'h001)
                    begin
                        state_next.st = ST_PUMP;
                        state_next.phase_cnt = 12'h000;
                    end
                end
                ST_PUMP:
                begin
                    if (state_reg.phase_cnt == PUMP_CYC - 12'h001)
                    begin
                        state_next.st = ST_BANK;
                        state_next.phase_cnt = 12'h000;
                    end
                end
                ST_BANK:
                begin
                    if (state_reg.phase_cnt == BANK_CYC - 12'h001)
                    begin
                        state_next.st = ST_RUN;
                        state_next.phase_cnt = 12'h000;
                    end
                end
                ST_RUN:
                begin
                    // Causes during the power-up phases only leave a flag.
                    state_next.phase_cnt = 12'h000;
                    if (warm_evt)
                    begin
                        state_next.st = ST_WARM;
                        state_next.warm_cnt = 6'h00;
                    end
                end
                ST_WARM:
                begin
                    // A new cause restarts the pulse so it never ends early.
                    state_next.phase_cnt = 12'h000;
                    if (warm_evt)
                    begin
                        state_next.warm_cnt = 6'h00;
                    end
                    else if (vclk_en && state_reg.warm_cnt == WARM_VCLK_CYC - 6'h01)
                    begin
                        state_next.st = ST_RUN;
                    end
                    else if (vclk_en)
                    begin
                        state_next.warm_cnt = state_reg.warm_cnt + 6'h01;
                    end
                end
                default:
                begin
                    state_next.st = ST_POR;
                end
            endcase
        end

        // Sticky flags: a set in the clearing cycle wins.
        state_next.exc_flags = (state_reg.exc_flags & ~exc_clr) | exc_set;
        state_next.glb_flags = (state_reg.glb_flags & ~glb_clr) | glb_set;

        // Control register; the software reset bit is a one-shot request.
        state_next.sw_req = 1'b0;
        if (apb_write && apb_req.paddr == CTRL_OFS)
        begin
            state_next.low_pwr = apb_req.pwdata[CTRL_LOWPWR_BIT];
            state_next.sw_req = apb_req.pwdata[CTRL_SWRST_BIT];
        end

        // Read data is captured in the setup cycle for the access phase.
        if (apb_setup)
        begin
            case (apb_req.paddr)
                EXC_STATUS_OFS:
                begin
                    state_next.prdata = {16'h0000, state_reg.exc_flags};
                end
                GLB_STATUS_OFS:
                begin
                    state_next.prdata = {16'h0000, state_reg.glb_flags};
                end
                CTRL_OFS:
                begin
                    state_next.prdata = {30'h00000000, state_reg.low_pwr, 1'b0};
                end
                SEQ_STATE_OFS:
                begin
                    state_next.prdata = {20'h00000, state_reg.filt_lvl[FLT_IO],
                        state_reg.filt_lvl[FLT_CORE], pin_drive,
                        (state_reg.st == ST_RUN), 5'h00, state_reg.st};
                end
                default:
                begin
                    // Unmapped addresses read as zero and answer with an error.
                    state_next.prdata = 32'h00000000;
                end
            endcase
        end
    end

    // State register; everything starts in power-on reset with the pin driven.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '{st: ST_POR, phase_cnt: 12'h000, hold_cnt: 12'h000,
                warm_cnt: 6'h00, vdiv_cnt: 8'h00, filt_cnt: 20'h00000, filt_lvl: 4'h0,
                warm_prev: 1'b0, exc_flags: FLAGS_RESET, glb_flags: FLAGS_RESET,
                low_pwr: CTRL_LOWPWR_RESET, sw_req: 1'b0, prdata: 32'h00000000};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Pins float at once on a bad core supply outside low power mode, with no clock involved.
    assign pins_hiz = !core_supply_ok && !state_reg.low_pwr;
    // Open drain: the output value is always low, only the enable moves.
    assign warm_reset_pin_n_o = 1'b0;
    assign warm_reset_pin_n_oe = pin_drive;
    assign core_power_good = state_reg.filt_lvl[FLT_CORE];
    assign io_power_good = state_reg.filt_lvl[FLT_IO];
    // Either supply missing isolates both sides, so ramp order is free.
    assign core_isolate = !(state_reg.filt_lvl[FLT_CORE] && state_reg.filt_lvl[FLT_IO]);
    assign io_isolate = core_isolate;
    assign por_int = por_now;
    assign cpu_reset_n = (state_reg.st == ST_RUN);
    assign cpu_boot_addr = BOOT_ADDR;
    assign apb_rsp.prdata = state_reg.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;

    // Step from the bank phase to running.
    sequence s_bank_end;
        (state_reg.st == ST_BANK) && (state_reg.phase_cnt == BANK_CYC - 12'h001) && !por_now;
    endsequence

    // Entry into a warm reset pulse.
    sequence s_warm_entry;
        (state_reg.st == ST_RUN) && warm_evt && !por_now;
    endsequence

    a_pins_float: assert property (@(posedge pclk) disable iff (!presetn)
        (!core_supply_ok && !state_reg.low_pwr) |-> pins_hiz)
        else $error("pins not floating on bad core supply");

    a_isolate_both: assert property (@(posedge pclk) disable iff (!presetn)
        (!core_power_good || !io_power_good) |-> (core_isolate && io_isolate))
        else $error("isolation missing while power good low");

    a_por_restart: assert property (@(posedge pclk) disable iff (!presetn)
        por_int |=> (state_reg.st == ST_POR) && warm_reset_pin_n_oe)
        else $error("power-on reset did not restart sequence");

    a_osc_length: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(state_reg.st) && state_reg.st == ST_FUSE)
        |-> $past(state_reg.st) == ST_OSC && $past(state_reg.phase_cnt) == OSC_CYC - 12'h001)
        else $error("oscillator phase length wrong");

    a_phase_order: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(state_reg.st) && state_reg.st == ST_BANK)
        |-> $past(state_reg.st) == ST_PUMP && $past(state_reg.phase_cnt) == PUMP_CYC - 12'h001)
        else $error("flash bank phase entered out of order");

    a_cpu_release: assert property (@(posedge pclk) disable iff (!presetn)
        s_bank_end |=> cpu_reset_n ##1 (cpu_reset_n || !presetn || $past(por_now)
        || $past(warm_evt)))
        else $error("cpu reset not released after bank phase");

    a_pin_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
        !warm_reset_pin_n_o)
        else $error("warm reset pin driven high");

    a_cold_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!warm_reset_pin_n_oe) |-> (state_reg.hold_cnt == POR_HOLD_CYC))
        else $error("warm pin released before cold hold elapsed");

    a_warm_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        s_warm_entry |=> warm_reset_pin_n_oe [*8] ##1 (state_reg.st == ST_WARM || por_now))
        else $error("warm reset pulse too short");

    a_cold_filter: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(state_reg.filt_lvl[FLT_COLD])
        |-> !$past(cold_reset_pin_n, 1) && !$past(cold_reset_pin_n, 12))
        else $error("cold reset filter fired on short pulse");

    a_sw_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_write && apb_req.paddr == CTRL_OFS && apb_req.pwdata[CTRL_SWRST_BIT])
        |=> ##1 state_reg.exc_flags[EXC_SW_BIT])
        else $error("software reset flag not set");

    a_osc_flag: assert property (@(posedge pclk) disable iff (!presetn)
        reset_evt.osc_fail |=> state_reg.glb_flags[GLB_OSC_BIT])
        else $error("oscillator fail flag not set");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(state_reg.exc_flags[EXC_EXT_BIT]) && !$past(exc_clr[EXC_EXT_BIT]))
        |-> state_reg.exc_flags[EXC_EXT_BIT])
        else $error("external reset flag lost without clear");

    a_low_power_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg.low_pwr && $past(state_reg.low_pwr, 1) && $past(state_reg.low_pwr, 6)
        && $past(state_reg.filt_lvl[FLT_CORE], 6)) |-> core_power_good)
        else $error("supply monitor active in low power mode");

endmodule : pus_sequencer

// >>> dv/pus_supervisor.sv
`timescale 1ns/1ps
// Board side: supply supervisor, warm reset line with pull-up, outside reset source.
module pus_supervisor (
    input wire logic core_good,
    input wire logic io_good,
    input wire logic hold_cold,
    input wire logic ext_pull,
    input wire logic warm_oe,
    output logic core_supply_ok,
    output logic io_supply_ok,
    output logic cold_reset_pin_n,
    output logic warm_level
);
    assign core_supply_ok = core_good;
    assign io_supply_ok = io_good;
    // Cold reset stays asserted while any supply is bad, so a dip also pulses it.
    assign cold_reset_pin_n = core_good & io_good & !hold_cold;
    // Open-drain line: the pull-up wins unless either party pulls low.
    assign warm_level = !(warm_oe | ext_pull);
endmodule : pus_supervisor

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pus_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    pus_apb_req_type req = '0;
    pus_apb_rsp_type rsp;
    pus_evt_type evt = '0;
    logic core_good = 1'b1, io_good = 1'b1, hold_cold = 1'b1, ext_pull = 1'b0;
    logic core_ok, io_ok, cold_n, warm_lvl, warm_o, warm_oe, pgc, pgi, iso_c, iso_i;
    logic hiz, por, cpu_n, err;
    logic [31:0] boot, rd;
    logic [31:0] exc_exp [5] = '{32'h20, 32'h2000, 32'h2000, 32'h0, 32'h0};
    logic [31:0] glb_exp [5] = '{32'h0, 32'h0, 32'h0, 32'h300, 32'h1};
    int mismatches = 0, n_checks = 0, cyc = 0, n, t;

    always #20 pclk = ~pclk;

    pus_supervisor u_sup (.core_good(core_good), .io_good(io_good), .hold_cold(hold_cold),
        .ext_pull(ext_pull), .warm_oe(warm_oe), .core_supply_ok(core_ok),
        .io_supply_ok(io_ok), .cold_reset_pin_n(cold_n), .warm_level(warm_lvl));

    pus_sequencer #(.VCLK_DIV(8'd1)) u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .core_supply_ok(core_ok), .io_supply_ok(io_ok),
        .cold_reset_pin_n(cold_n), .warm_reset_pin_n_i(warm_lvl), .warm_reset_pin_n_o(warm_o),
        .warm_reset_pin_n_oe(warm_oe), .reset_evt(evt), .core_power_good(pgc),
        .io_power_good(pgi), .core_isolate(iso_c), .io_isolate(iso_i), .pins_hiz(hiz),
        .por_int(por), .cpu_reset_n(cpu_n), .cpu_boot_addr(boot));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        // Only the run ceiling ends a wait for the answer.
        do
        begin
            @(posedge pclk);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(rd, exp, what);
    endtask : rd_chk

    // Waits for the device to pull the warm line and counts cycles it stays low.
    task automatic warm_len();
        t = 0;
        n = 0;
        while (warm_oe !== 1'b1 && t < 20)
        begin
            @(negedge pclk);
            t++;
        end
        while (warm_oe === 1'b1 && n < 200)
        begin
            @(negedge pclk);
            n++;
        end
    endtask : warm_len

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // Run ceiling well above the power-up sequence plus all warm resets.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        rd_chk(EXC_STATUS_OFS, 32'h8000, "exc power-up flag");
        hold_cold <= 1'b0;
        n = 0;
        while (por !== 1'b0 && n < 50)
        begin
            @(negedge pclk);
            n++;
        end
        n = 0;
        t = 0;
        while (cpu_n !== 1'b1 && n < 5000)
        begin
            @(negedge pclk);
            n++;
            if (warm_oe === 1'b1)
                t = n;
        end
        check(32'(n >= 3497 && n <= 3499), 32'h1, "cpu release time");
        check(32'(t >= 2256 && t <= 2258), 32'h1, "cold pin hold");
        check(boot, 32'h0, "boot address");
        check(32'({pgc, pgi, iso_c, iso_i, warm_o}), 32'h18, "power good");
        rd_chk(SEQ_STATE_OFS, 32'hd05, "sequencer state");
        apb(1'b1, EXC_STATUS_OFS, 32'hffff);
        rd_chk(EXC_STATUS_OFS, 32'h0, "exc cleared");
        // Every on-chip cause in turn: pulse length, its flag, then a W1C clear.
        for (int i = 0; i < 5; i++)
        begin
            @(posedge pclk);
            evt <= pus_evt_type'(5'b1 << i);
            @(posedge pclk);
            evt <= '0;
            warm_len();
            check(32'(n >= 32 && n <= 33), 32'h1, "warm pulse");
            rd_chk(EXC_STATUS_OFS, exc_exp[i], "exc cause");
            rd_chk(GLB_STATUS_OFS, glb_exp[i], "glb cause");
            check(32'(cpu_n), 32'h1, "cpu back");
            apb(1'b1, EXC_STATUS_OFS, 32'hffff);
            apb(1'b1, GLB_STATUS_OFS, 32'hffff);
        end
        apb(1'b1, CTRL_OFS, 32'h1);
        warm_len();
        check(32'(n >= 32 && n <= 33), 32'h1, "soft pulse");
        rd_chk(EXC_STATUS_OFS, 32'h10, "exc soft");
        apb(1'b1, EXC_STATUS_OFS, 32'hffff);
        // A short outside pulse is filtered out; a long one resets.
        // Let the released line settle first, so a missing filter would show.
        repeat (16) @(posedge pclk);
        ext_pull <= 1'b1;
        repeat (8) @(posedge pclk);
        ext_pull <= 1'b0;
        repeat (30) @(posedge pclk);
        rd_chk(EXC_STATUS_OFS, 32'h0, "short ext pulse");
        ext_pull <= 1'b1;
        repeat (20) @(posedge pclk);
        ext_pull <= 1'b0;
        warm_len();
        rd_chk(EXC_STATUS_OFS, 32'h8, "exc external");
        apb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0, "unmapped read");
        check(32'(err), 32'h1, "unmapped error");
        // Low power mode: a short core dip is ignored and pins stay driven.
        apb(1'b1, CTRL_OFS, 32'h2);
        rd_chk(CTRL_OFS, 32'h2, "low power bit");
        core_good <= 1'b0;
        repeat (8) @(negedge pclk);
        check(32'({pgc, por, hiz}), 32'h4, "low power quiet");
        @(posedge pclk);
        core_good <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h0);
        io_good <= 1'b0;
        repeat (5) @(posedge pclk);
        io_good <= 1'b1;
        repeat (10) @(negedge pclk);
        check(32'({pgi, por}), 32'h2, "supply glitch");
        @(posedge pclk);
        core_good <= 1'b0;
        #1;
        check(32'(hiz), 32'h1, "pins float");
        repeat (12) @(negedge pclk);
        check(32'({pgc, iso_c, iso_i, por, cpu_n, warm_lvl}), 32'h1c, "core drop");
        give_verdict();
    end
endmodule : tb_top
